// >>> rtl/irrx_map.svh
// Register map, field positions, reset values and limits of the IR receiver.
// Assumes inclusion by bare name; definitions only.
`ifndef IRRX_MAP_SVH
`define IRRX_MAP_SVH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define IRRX_OFS_CTRL2     8'h00
`define IRRX_OFS_LEADER    8'h04
`define IRRX_OFS_THRESH    8'h08
`define IRRX_OFS_STATUS    8'h0C
`define IRRX_OFS_IRQ_EN    8'h10
`define IRRX_OFS_IRQ_CLR   8'h14
`define IRRX_OFS_RX_DATA   8'h18
`define IRRX_OFS_RX_BITS   8'h1C

// ----------------------------------------------------------------------------
// Control register two fields
// ----------------------------------------------------------------------------
`define IRRX_C2_LIEN       31
`define IRRX_C2_EDIEN      30
`define IRRX_C2_LD         25
`define IRRX_C2_PHM        24
`define IRRX_C2_LL_LSB     8
`define IRRX_C2_DMAX_LSB   0
`define IRRX_C2_WMASK      32'hC300_FFFF
`define IRRX_C2_RST        32'h0000_FFFF

// ----------------------------------------------------------------------------
// Other fields and resets
// ----------------------------------------------------------------------------
`define IRRX_LEAD_MAX_LSB  8
`define IRRX_LEAD_MIN_LSB  0
`define IRRX_LEADER_WMASK  32'h0000_FFFF
`define IRRX_LEADER_RST    32'h0000_0000
`define IRRX_THR_HI_LSB    8
`define IRRX_THR_LO_LSB    0
`define IRRX_THRESH_WMASK  32'h0000_7F7F
`define IRRX_THRESH_RST    32'h0000_0000
`define IRRX_IRQ_EN_RST    4'h0
`define IRRX_LIMIT_OFF     8'hFF
`define IRRX_EV_LEADER     0
`define IRRX_EV_FALL       1
`define IRRX_EV_LOW        2
`define IRRX_EV_MAXCYC     3
`define IRRX_NUM_EV        4
`define IRRX_FS_DIV        8

`endif

// >>> rtl/irrx_pkg.sv
// Types shared by the IR receiver files.
// Assumes nothing of its surroundings.
package irrx_pkg;

  // --------------------------------------------------------------------------
  // Control register two, decoded
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       leader_irq_enable;
    logic       fall_edge_irq_enable;
    logic       leaderless_accept;
    logic       phase_method_select;
    logic [7:0] excess_low_limit;
    logic [7:0] max_bit_cycle_limit;
  } irrx_ctrl_s;

  // --------------------------------------------------------------------------
  // Receiver states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    IRRX_IDLE  = 3'b001,
    IRRX_FIRST = 3'b010,
    IRRX_DATA  = 3'b100
  } irrx_state_e;

endpackage

// >>> rtl/irrx_sync.sv
// Pin synchroniser with falling edge detection.
// Assumes an asynchronous input pin and a single clock.
module irrx_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      level,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic meta_nxt;
  logic sync_nxt;
  logic prev_nxt;

  // --------------------------------------------------------------------------
  // Two stage synchroniser, then edge history
  // --------------------------------------------------------------------------
  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign level = sync_r;
  assign fall  = prev_r & ~sync_r;

endmodule

// >>> rtl/irrx_irq.sv
// Sticky event status with enable gating onto one level interrupt.
// Assumes one-cycle event pulses and a one-cycle clear strobe.
module irrx_irq #(
  parameter int N = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [N-1:0] set_ev,
  input  wire logic         clr_we,
  input  wire logic [N-1:0] clr_bits,
  input  wire logic [N-1:0] enable,
  output logic      [N-1:0] status,
  output logic              irq
);

  logic [N-1:0] status_r;
  logic [N-1:0] status_nxt;

  // --------------------------------------------------------------------------
  // Set wins over clear
  // --------------------------------------------------------------------------
  always_comb begin
    status_nxt = status_r;
    if (clr_we) begin
      status_nxt = status_nxt & ~clr_bits;
    end
    status_nxt = status_nxt | set_ev;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign status = status_r;
  assign irq    = |(status_r & enable);

endmodule

// >>> rtl/irrx_top.sv
// IR remote receiver: control register two, leader and data decoding,
// excess-low and maximum-cycle detection, Wishbone classic register slave.
// Assumes a demodulated IR input pin, idle high, and one 250 MHz clock.
`include "irrx_map.svh"

module irrx_top #(
  parameter int FS_DIV = `IRRX_FS_DIV
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ir_in,
  output logic             irq_o,
  output logic             rx_active
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam int NEV = `IRRX_NUM_EV;

  logic [31:0]           ctrl2_r;
  logic [31:0]           ctrl2_nxt;
  logic [31:0]           leader_r;
  logic [31:0]           leader_nxt;
  logic [31:0]           thresh_r;
  logic [31:0]           thresh_nxt;
  logic [NEV-1:0]        irq_en_r;
  logic [NEV-1:0]        irq_en_nxt;
  logic                  ack_r;
  logic                  ack_nxt;
  logic [31:0]           rdata_r;
  logic [31:0]           rdata_nxt;
  logic                  clr_we;
  logic                  bus_req;
  logic                  bus_wr;
  logic [NEV-1:0]        status;
  logic [NEV-1:0]        ev;
  irrx_pkg::irrx_ctrl_s  ctrl;

  logic                  ir_level;
  logic                  ir_fall;

  logic [15:0]           fs_cnt_r;
  logic [15:0]           fs_cnt_nxt;
  logic                  fs_tick;
  irrx_pkg::irrx_state_e state_r;
  irrx_pkg::irrx_state_e state_nxt;
  logic [9:0]            cyc_cnt_r;
  logic [9:0]            cyc_cnt_nxt;
  logic [8:0]            low_cnt_r;
  logic [8:0]            low_cnt_nxt;
  logic [31:0]           shift_r;
  logic [31:0]           shift_nxt;
  logic [5:0]            nbits_r;
  logic [5:0]            nbits_nxt;
  logic [31:0]           rx_data_r;
  logic [31:0]           rx_data_nxt;
  logic [5:0]            rx_bits_r;
  logic [5:0]            rx_bits_nxt;

  logic [9:0]            lead_min4;
  logic [9:0]            lead_max4;
  logic                  is_leader;
  logic                  over_max;
  logic                  over_low;
  logic                  bit_val;
  logic                  ev_leader;
  logic                  ev_low;
  logic                  ev_max;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] wr_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel,
                                           input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & mask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  function automatic irrx_pkg::irrx_ctrl_s ctrl_decode(input logic [31:0] w);
    irrx_pkg::irrx_ctrl_s c;
    c.leader_irq_enable    = w[`IRRX_C2_LIEN];
    c.fall_edge_irq_enable = w[`IRRX_C2_EDIEN];
    c.leaderless_accept    = w[`IRRX_C2_LD];
    c.phase_method_select  = w[`IRRX_C2_PHM];
    c.excess_low_limit     = w[`IRRX_C2_LL_LSB +: 8];
    c.max_bit_cycle_limit  = w[`IRRX_C2_DMAX_LSB +: 8];
    return c;
  endfunction

  assign ctrl = ctrl_decode(ctrl2_r);

  // --------------------------------------------------------------------------
  // Wishbone classic slave
  // --------------------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign bus_wr  = bus_req & wb_we_i;
  assign clr_we  = bus_wr & (wb_adr_i == `IRRX_OFS_IRQ_CLR) & wb_sel_i[0];

  always_comb begin
    ctrl2_nxt  = ctrl2_r;
    leader_nxt = leader_r;
    thresh_nxt = thresh_r;
    irq_en_nxt = irq_en_r;
    ack_nxt    = bus_req;
    rdata_nxt  = rdata_r;
    if (bus_wr) begin
      unique case (wb_adr_i)
        `IRRX_OFS_CTRL2:  ctrl2_nxt  = wr_merge(ctrl2_r, wb_dat_i, wb_sel_i,
                                                `IRRX_C2_WMASK);
        `IRRX_OFS_LEADER: leader_nxt = wr_merge(leader_r, wb_dat_i, wb_sel_i,
                                                `IRRX_LEADER_WMASK);
        `IRRX_OFS_THRESH: thresh_nxt = wr_merge(thresh_r, wb_dat_i, wb_sel_i,
                                                `IRRX_THRESH_WMASK);
        `IRRX_OFS_IRQ_EN: begin
          if (wb_sel_i[0]) begin
            irq_en_nxt = wb_dat_i[NEV-1:0];
          end
        end
        default: ;
      endcase
    end
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `IRRX_OFS_CTRL2:   rdata_nxt = ctrl2_r;
        `IRRX_OFS_LEADER:  rdata_nxt = leader_r;
        `IRRX_OFS_THRESH:  rdata_nxt = thresh_r;
        `IRRX_OFS_STATUS:  rdata_nxt = {{(32-NEV){1'b0}}, status};
        `IRRX_OFS_IRQ_EN:  rdata_nxt = {{(32-NEV){1'b0}}, irq_en_r};
        `IRRX_OFS_RX_DATA: rdata_nxt = rx_data_r;
        `IRRX_OFS_RX_BITS: rdata_nxt = {26'h000_0000, rx_bits_r};
        default:           rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl2_r  <= `IRRX_C2_RST;
      leader_r <= `IRRX_LEADER_RST;
      thresh_r <= `IRRX_THRESH_RST;
      irq_en_r <= `IRRX_IRQ_EN_RST;
      ack_r    <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else begin
      ctrl2_r  <= ctrl2_nxt;
      leader_r <= leader_nxt;
      thresh_r <= thresh_nxt;
      irq_en_r <= irq_en_nxt;
      ack_r    <= ack_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // --------------------------------------------------------------------------
  // Input pin and sampling clock
  // --------------------------------------------------------------------------
  irrx_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  (ir_in),
    .level   (ir_level),
    .fall    (ir_fall)
  );

  assign fs_tick = (fs_cnt_r == 16'(FS_DIV - 1));

  always_comb begin
    fs_cnt_nxt = fs_tick ? 16'h0000 : fs_cnt_r + 16'h0001;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fs_cnt_r <= 16'h0000;
    end else begin
      fs_cnt_r <= fs_cnt_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Cycle classification
  // --------------------------------------------------------------------------
  assign lead_min4 = {leader_r[`IRRX_LEAD_MIN_LSB +: 8], 2'b00};
  assign lead_max4 = {leader_r[`IRRX_LEAD_MAX_LSB +: 8], 2'b00};
  assign is_leader = (lead_max4 != 10'h000) && (cyc_cnt_r > lead_min4) &&
                     (cyc_cnt_r <= lead_max4);
  assign over_max  = (ctrl.max_bit_cycle_limit != `IRRX_LIMIT_OFF) &&
                     (cyc_cnt_r > {2'b00, ctrl.max_bit_cycle_limit});
  assign over_low  = (ctrl.excess_low_limit != `IRRX_LIMIT_OFF) &&
                     (low_cnt_r > {1'b0, ctrl.excess_low_limit});
  assign bit_val   = ctrl.phase_method_select ?
                     (cyc_cnt_r > {3'b000, thresh_r[`IRRX_THR_HI_LSB +: 7]}) :
                     (cyc_cnt_r > {3'b000, thresh_r[`IRRX_THR_LO_LSB +: 7]});

  // --------------------------------------------------------------------------
  // Receiver state machine
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    cyc_cnt_nxt = cyc_cnt_r;
    low_cnt_nxt = low_cnt_r;
    shift_nxt   = shift_r;
    nbits_nxt   = nbits_r;
    rx_data_nxt = rx_data_r;
    rx_bits_nxt = rx_bits_r;
    ev_leader   = 1'b0;
    ev_low      = 1'b0;
    ev_max      = 1'b0;
    if (fs_tick && cyc_cnt_r != 10'h3FF) begin
      cyc_cnt_nxt = cyc_cnt_r + 10'h001;
    end
    if (ir_level || state_r == irrx_pkg::IRRX_IDLE) begin
      low_cnt_nxt = 9'h000;
    end else if (fs_tick && low_cnt_r != 9'h1FF) begin
      low_cnt_nxt = low_cnt_r + 9'h001;
    end
    unique case (state_r)
      irrx_pkg::IRRX_IDLE: begin
        if (ir_fall) begin
          state_nxt   = irrx_pkg::IRRX_FIRST;
          cyc_cnt_nxt = 10'h000;
          shift_nxt   = 32'h0000_0000;
          nbits_nxt   = 6'h00;
        end
      end
      irrx_pkg::IRRX_FIRST: begin
        if (ir_fall) begin
          cyc_cnt_nxt = 10'h000;
          if (is_leader) begin
            state_nxt = irrx_pkg::IRRX_DATA;
            ev_leader = ctrl.leader_irq_enable;
          end else if (ctrl.leaderless_accept && cyc_cnt_r <= lead_min4) begin
            state_nxt = irrx_pkg::IRRX_DATA;
            shift_nxt = {shift_r[30:0], bit_val};
            nbits_nxt = 6'h01;
          end
          // Otherwise the cycle restarts the leader hunt
        end
      end
      irrx_pkg::IRRX_DATA: begin
        if (ir_fall) begin
          cyc_cnt_nxt = 10'h000;
          if (over_max) begin
            ev_max      = 1'b1;
            state_nxt   = irrx_pkg::IRRX_IDLE;
            rx_data_nxt = shift_r;
            rx_bits_nxt = nbits_r;
          end else begin
            shift_nxt = {shift_r[30:0], bit_val};
            if (nbits_r != 6'h20) begin
              nbits_nxt = nbits_r + 6'h01;
            end
          end
        end
      end
      default: state_nxt = irrx_pkg::IRRX_IDLE;
    endcase
    if (over_low && state_r != irrx_pkg::IRRX_IDLE) begin
      ev_low      = 1'b1;
      state_nxt   = irrx_pkg::IRRX_IDLE;
      rx_data_nxt = shift_r;
      rx_bits_nxt = nbits_r;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r   <= irrx_pkg::IRRX_IDLE;
      cyc_cnt_r <= 10'h000;
      low_cnt_r <= 9'h000;
      shift_r   <= 32'h0000_0000;
      nbits_r   <= 6'h00;
      rx_data_r <= 32'h0000_0000;
      rx_bits_r <= 6'h00;
    end else begin
      state_r   <= state_nxt;
      cyc_cnt_r <= cyc_cnt_nxt;
      low_cnt_r <= low_cnt_nxt;
      shift_r   <= shift_nxt;
      nbits_r   <= nbits_nxt;
      rx_data_r <= rx_data_nxt;
      rx_bits_r <= rx_bits_nxt;
    end
  end

  assign rx_active = (state_r != irrx_pkg::IRRX_IDLE);

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  always_comb begin
    ev                      = '0;
    ev[`IRRX_EV_LEADER]     = ev_leader;
    ev[`IRRX_EV_FALL]       = ir_fall & ctrl.fall_edge_irq_enable;
    ev[`IRRX_EV_LOW]        = ev_low;
    ev[`IRRX_EV_MAXCYC]     = ev_max;
  end

  irrx_irq #(
    .N (NEV)
  ) u_irq (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .set_ev   (ev),
    .clr_we   (clr_we),
    .clr_bits (wb_dat_i[NEV-1:0]),
    .enable   (irq_en_r),
    .status   (status),
    .irq      (irq_o)
  );

endmodule

// >>> testbench/irrx_ir_model.sv
// Remote input source: drives the demodulated line, idle high.
// Assumes the caller enters each task just after a rising clock edge.
module irrx_ir_model (
  input  wire logic clk,
  output logic      ir
);
  timeunit 1ns;
  timeprecision 100ps;

  initial ir = 1'b1;

  // One cycle: short low, then high for the rest
  task automatic burst(input int c);
    ir <= 1'b0;
    repeat (4) @(posedge clk);
    ir <= 1'b1;
    repeat (c - 4) @(posedge clk);
  endtask

  // Long low, then back to idle for one cycle
  task automatic hold_low(input int n);
    ir <= 1'b0;
    repeat (n) @(posedge clk);
    ir <= 1'b1;
    @(posedge clk);
  endtask
endmodule

// >>> testbench/irrx_sva.sv
// Checker for the IR receiver top: handshake, interrupt gating, frame end.
// Assumes binding to irrx_top; the shadows honour the byte enables.
module irrx_sva #(
  parameter int FS_DIV = 8
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        ir_in,
  input  wire logic        irq_o,
  input  wire logic        rx_active
);
  logic [7:0] ll;
  logic [7:0] dmax;
  logic       edien;
  logic [3:0] ien;
  int         low_cnt;
  int         lim;

  // ---------------------------------------------------------------------------
  // Shadow of written settings
  // ---------------------------------------------------------------------------
  assign lim = (int'(ll) + 4) * FS_DIV + 8;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ll      <= 8'hFF;
      dmax    <= 8'hFF;
      edien   <= 1'b0;
      ien     <= 4'h0;
      low_cnt <= 0;
    end else begin
      low_cnt <= ir_in ? 0 : low_cnt + 1;
      if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00) begin
        ll    <= wb_sel_i[1] ? wb_dat_i[15:8] : ll;
        dmax  <= wb_sel_i[0] ? wb_dat_i[7:0] : dmax;
        edien <= wb_sel_i[3] ? wb_dat_i[30] : edien;
      end
      if (wb_ack_o && wb_we_i && wb_adr_i == 8'h10 && wb_sel_i[0]) begin
        ien <= wb_dat_i[3:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_RESP: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  AST_RSVD_ZERO: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> (wb_dat_o & 32'h3CFF_0000) == 32'h0000_0000)
    else $error("unused control bits read nonzero");
  AST_LOW_END: assert property (ll != 8'hFF && low_cnt == lim |-> !rx_active)
    else $error("excess low did not end reception");
  AST_LOW_KEEP: assert property (
    rx_active && ll != 8'hFF && dmax == 8'hFF && low_cnt > 8
    && low_cnt < (int'(ll) - 2) * FS_DIV |=> rx_active)
    else $error("reception ended before low limit");
  AST_NO_END: assert property (
    rx_active && ll == 8'hFF && dmax == 8'hFF && !wb_ack_o |=> rx_active)
    else $error("reception ended with both detectors off");
  AST_IRQ_MASK: assert property (ien == 4'h0 && !wb_ack_o |-> !irq_o)
    else $error("interrupt high with all enables clear");
  AST_FALL_IRQ: assert property ($fell(ir_in) && edien && ien[1] |-> ##[2:10] irq_o)
    else $error("no interrupt after falling edge");
endmodule

bind irrx_top irrx_sva #(.FS_DIV(FS_DIV)) u_sva (
  .clk       (clk),
  .sys_rst   (sys_rst),
  .wb_cyc_i  (wb_cyc_i),
  .wb_stb_i  (wb_stb_i),
  .wb_we_i   (wb_we_i),
  .wb_adr_i  (wb_adr_i),
  .wb_sel_i  (wb_sel_i),
  .wb_dat_i  (wb_dat_i),
  .wb_dat_o  (wb_dat_o),
  .wb_ack_o  (wb_ack_o),
  .ir_in     (ir_in),
  .irq_o     (irq_o),
  .rx_active (rx_active)
);

// >>> testbench/ir_remote_rx_control_two_tb_top.sv
// Self-checking bench for the IR receiver top.
// Assumes the remote input model and the bound checker are compiled first.
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module ir_remote_rx_control_two_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int FSD = 2;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'hF;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        ir;
  logic        irq;
  logic        act;
  int          bad_count = 0;
  int          comparisons = 0;

  always #2 clk = ~clk;

  irrx_top #(.FS_DIV(FSD)) uut (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .wb_cyc_i  (cyc),
    .wb_stb_i  (stb),
    .wb_we_i   (we),
    .wb_adr_i  (adr),
    .wb_sel_i  (sel),
    .wb_dat_i  (wdat),
    .wb_dat_o  (rdat),
    .wb_ack_o  (ack),
    .ir_in     (ir),
    .irq_o     (irq),
    .rx_active (act)
  );

  irrx_ir_model ir_m (
    .clk (clk),
    .ir  (ir)
  );

  // ---------------------------------------------------------------------------
  // Bus and helper tasks
  // ---------------------------------------------------------------------------
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      results();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(a, 1'b0, 32'h0000_0000, q);
  endtask

  task automatic frame(input int a, input int b, input int c);
    ir_m.burst(a);
    ir_m.burst(b);
    ir_m.burst(c);
    ir_m.hold_low(100);
    repeat (8) @(posedge clk);
    wr(8'h14, 32'h0000_0000);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] q;
    rd(8'h00, q);
    `CHK("ctrl2 reset", 32'h0000_FFFF, q)
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, q);
    `CHK("ctrl2 mask", 32'hC300_FFFF, q)
    sel <= 4'h2;
    wr(8'h00, 32'h0000_0000);
    sel <= 4'hF;
    rd(8'h00, q);
    `CHK("ctrl2 lane", 32'hC300_00FF, q)
    rd(8'h20, q);
    `CHK("unmapped", 32'h0000_0000, q)
    wr(8'h04, 32'h0000_0502);
    wr(8'h08, 32'h0000_0C03);
    rd(8'h08, q);
    `CHK("thresholds", 32'h0000_0C03, q)
    wr(8'h00, 32'h0000_FFFF);
  endtask

  task automatic t_fall;
    logic [31:0] q;
    wr(8'h00, 32'h4000_FFFF);
    wr(8'h10, 32'h0000_0002);
    wr(8'h14, 32'h0000_000F);
    ir_m.hold_low(4);
    repeat (12) @(posedge clk);
    rd(8'h0C, q);
    `CHK("fall status", 1'b1, q[1])
    `CHK("fall irq", 1'b1, irq)
    wr(8'h10, 32'h0000_0000);
    `CHK("masked irq", 1'b0, irq)
    wr(8'h10, 32'h0000_0002);
    wr(8'h14, 32'h0000_0002);
    rd(8'h0C, q);
    `CHK("cleared status", 1'b0, q[1])
    `CHK("cleared irq", 1'b0, irq)
    wr(8'h00, 32'h0000_FFFF);
    ir_m.hold_low(4);
    repeat (12) @(posedge clk);
    rd(8'h0C, q);
    `CHK("fall off", 1'b0, q[1])
  endtask

  task automatic t_low;
    logic [31:0] q;
    wr(8'h00, 32'h0000_14FF);
    wr(8'h14, 32'h0000_000F);
    wr(8'h10, 32'h0000_0004);
    ir_m.hold_low(30);
    rd(8'h0C, q);
    `CHK("short low", 1'b0, q[2])
    ir_m.hold_low(60);
    repeat (8) @(posedge clk);
    rd(8'h0C, q);
    `CHK("excess low", 1'b1, q[2])
    `CHK("low irq", 1'b1, irq)
    `CHK("low ends rx", 1'b0, act)
    wr(8'h00, 32'h0000_FFFF);
    wr(8'h14, 32'h0000_000F);
    ir_m.hold_low(600);
    rd(8'h0C, q);
    `CHK("low off", 1'b0, q[2])
    `CHK("rx kept", 1'b1, act)
    wr(8'h00, 32'h0000_14FF);
    ir_m.hold_low(60);
    repeat (8) @(posedge clk);
  endtask

  task automatic t_lead;
    logic [31:0] q;
    for (int ld = 0; ld < 2; ld++) begin
      wr(8'h00, 32'h8000_1EFF | (32'(ld) << 25));
      wr(8'h14, 32'h0000_000F);
      frame(12, 12, 30);
      rd(8'h0C, q);
      `CHK("leader status", 1'(1 - ld), q[0])
      rd(8'h1C, q);
      `CHK("bit count", (ld == 1) ? 6'h03 : 6'h00, q[5:0])
      rd(8'h18, q);
      if (ld == 1) `CHK("short first data", 3'h7, q[2:0])
    end
  endtask

  task automatic t_data;
    logic [31:0] q;
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, 32'h0000_1EFF | (32'(i) << 31) | (32'(i) << 24));
      wr(8'h14, 32'h0000_000F);
      frame(28, 16, 30);
      rd(8'h0C, q);
      `CHK("leader irq en", 1'(i), q[0])
      rd(8'h18, q);
      `CHK("decoded bits", (i == 1) ? 2'h1 : 2'h3, q[1:0])
      rd(8'h1C, q);
      `CHK("data count", 6'h02, q[5:0])
    end
  endtask

  task automatic t_max;
    logic [31:0] q;
    wr(8'h00, 32'h0000_1E14);
    wr(8'h14, 32'h0000_000F);
    frame(28, 30, 36);
    rd(8'h0C, q);
    `CHK("cycle in limit", 1'b0, q[3])
    frame(28, 30, 60);
    rd(8'h0C, q);
    `CHK("cycle over limit", 1'b1, q[3])
    `CHK("max ends rx", 1'b0, act)
    wr(8'h00, 32'h0000_1EFF);
    wr(8'h14, 32'h0000_000F);
    frame(28, 30, 60);
    rd(8'h0C, q);
    `CHK("max off", 1'b0, q[3])
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_fall();
    t_low();
    t_lead();
    t_data();
    t_max();
    results();
  end
endmodule
